/* src/core_memory_map_decode.sv */
// Data and program memory address decode for the execution core.
`timescale 1ns/1ns
module core_memory_map_decode #(
  parameter int PROG_WORDS = memmap_pkg::PROG_WORDS_DEF,
  parameter int GP_BANKS = memmap_pkg::GP_BANKS_DEF,
  parameter int SPEC_BANKS = 32
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Program sequencing
  input wire logic advance_i,
  input wire logic irq_take_i,
  input wire logic jump_i,
  input wire logic [memmap_pkg::PC_W-1:0] jump_addr_i,
  output logic [memmap_pkg::PC_W-1:0] pc_o,
  output logic [memmap_pkg::PC_W-1:0] fetch_addr_o,
  // Program memory address, read strobe and returned word for an indirect program read
  output logic [memmap_pkg::PC_W-1:0] prog_addr_o,
  output logic prog_rd_o,
  input wire logic [memmap_pkg::INSN_W-1:0] prog_word_i,
  // Data access from the execution core
  input wire memmap_pkg::data_req_t req_i,
  output memmap_pkg::data_rsp_t rsp_o,
  // Peripheral special function window
  output logic spec_rd_o,
  output logic spec_wr_o,
  output logic [memmap_pkg::DADDR_W-1:0] spec_addr_o,
  output logic [7:0] spec_wdata_o,
  input wire logic spec_hit_i,
  input wire logic [7:0] spec_rdata_i,
  // Core register contents for the execution core
  output logic [memmap_pkg::BANK_W-1:0] bank_o,
  output logic [7:0] accumulator_o
);

  localparam int GP_DEPTH = memmap_pkg::GP_BYTES * GP_BANKS;
  localparam int GP_AW = $clog2(GP_DEPTH + memmap_pkg::COMMON_BYTES);

  // ****************************************
  // Core registers
  // ****************************************
  logic [7:0] ptr0_lo_r, ptr0_hi_r, ptr1_lo_r, ptr1_hi_r;
  logic [7:0] bank_r, acc_r, latch_hi_r, irqc_r, flags_r;
  logic stall_r;
  logic [7:0] rdata_r;
  logic rvalid_r;
  logic extra_r;

  // ****************************************
  // Decode
  // ****************************************
  logic [15:0] ptr_full;
  logic to_prog;
  logic [memmap_pkg::DADDR_W-1:0] daddr;
  logic [memmap_pkg::BANK_W-1:0] dbank;
  logic [memmap_pkg::OFS_W-1:0] dofs;
  logic is_core, is_spec, is_gp, is_common;
  logic gp_we;
  logic [GP_AW-1:0] gp_addr;
  logic [7:0] gp_rdata;
  logic [7:0] core_rdata;
  logic access;

  function automatic logic [memmap_pkg::DADDR_W-1:0] join_addr(
    input logic [memmap_pkg::BANK_W-1:0] bank,
    input logic [memmap_pkg::OFS_W-1:0] ofs
  );
    join_addr = {bank, ofs};
  endfunction

  assign access = req_i.rd | req_i.wr;
  assign ptr_full = req_i.ptr_sel ? {ptr1_hi_r, ptr1_lo_r}
                                  : {ptr0_hi_r, ptr0_lo_r};
  assign to_prog = req_i.indirect &&
                   ptr_full[memmap_pkg::PTR_PROG_BIT + 8];

  // Indirect data addresses take the low bits of the pointer pair.
  assign daddr = req_i.indirect ? ptr_full[memmap_pkg::DADDR_W-1:0]
                 : join_addr(bank_r[memmap_pkg::BANK_W-1:0],
                             req_i.offset);
  assign dbank = daddr[memmap_pkg::DADDR_W-1:memmap_pkg::OFS_W];
  assign dofs = daddr[memmap_pkg::OFS_W-1:0];

  // Core, peripheral and common slices repeat in every bank; GP bytes only below GP_BANKS.
  assign is_core = dofs <= memmap_pkg::OFS_CORE_LAST;
  assign is_spec = !is_core && dofs <= memmap_pkg::OFS_SPEC_LAST;
  assign is_gp = dofs >= memmap_pkg::OFS_GP_FIRST &&
                 dofs <= memmap_pkg::OFS_GP_LAST &&
                 int'(dbank) < GP_BANKS;
  assign is_common = dofs >= memmap_pkg::OFS_COMMON_FIRST;

  always_comb begin
    gp_addr = '0;
    if (is_common) begin
      gp_addr = GP_AW'(GP_DEPTH +
                int'(dofs - memmap_pkg::OFS_COMMON_FIRST));
    end else if (is_gp) begin
      gp_addr = GP_AW'(int'(dbank) * memmap_pkg::GP_BYTES +
                int'(dofs - memmap_pkg::OFS_GP_FIRST));
    end
  end

  // Writes aimed at program memory are dropped here.
  assign gp_we = req_i.wr && !to_prog && (is_gp || is_common);

  gp_ram #(
    .DEPTH(GP_DEPTH + memmap_pkg::COMMON_BYTES),
    .AW(GP_AW)
  ) u_gp_ram (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .we_i(gp_we),
    .addr_i(gp_addr),
    .wdata_i(req_i.wdata),
    .rdata_o(gp_rdata)
  );

  prog_addr_gen #(
    .PROG_WORDS(PROG_WORDS)
  ) u_prog_addr_gen (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .advance_i(advance_i),
    .irq_take_i(irq_take_i),
    .jump_i(jump_i),
    .jump_addr_i(jump_addr_i),
    .pc_o(pc_o),
    .fetch_addr_o(fetch_addr_o)
  );

  // ****************************************
  // Core register read mux
  // ****************************************
  always_comb begin
    core_rdata = 8'h00;
    unique case (dofs)
      memmap_pkg::PROGRAM_COUNTER_LOW: core_rdata = pc_o[7:0];
      memmap_pkg::CORE_FLAGS: core_rdata = flags_r;
      memmap_pkg::POINTER0_LOW: core_rdata = ptr0_lo_r;
      memmap_pkg::POINTER0_HIGH: core_rdata = ptr0_hi_r;
      memmap_pkg::POINTER1_LOW: core_rdata = ptr1_lo_r;
      memmap_pkg::POINTER1_HIGH: core_rdata = ptr1_hi_r;
      memmap_pkg::BANK_SELECTOR: core_rdata = bank_r;
      memmap_pkg::ACCUMULATOR_ALIAS: core_rdata = acc_r;
      memmap_pkg::PROGRAM_COUNTER_LATCH_HIGH: core_rdata = latch_hi_r;
      memmap_pkg::IRQ_CONTROL: core_rdata = irqc_r;
      // Indirect registers read as zero when reached through themselves.
      default: core_rdata = 8'h00;
    endcase
  end

  // ****************************************
  // Core register writes
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ptr0_lo_r <= memmap_pkg::REG_RESET;
      ptr0_hi_r <= memmap_pkg::REG_RESET;
      ptr1_lo_r <= memmap_pkg::REG_RESET;
      ptr1_hi_r <= memmap_pkg::REG_RESET;
      bank_r <= memmap_pkg::REG_RESET;
      latch_hi_r <= memmap_pkg::REG_RESET;
      irqc_r <= memmap_pkg::REG_RESET;
      flags_r <= memmap_pkg::REG_RESET;
    end else if (req_i.wr && !to_prog && is_core) begin
      unique case (dofs)
        memmap_pkg::POINTER0_LOW: ptr0_lo_r <= req_i.wdata;
        memmap_pkg::POINTER0_HIGH: ptr0_hi_r <= req_i.wdata;
        memmap_pkg::POINTER1_LOW: ptr1_lo_r <= req_i.wdata;
        memmap_pkg::POINTER1_HIGH: ptr1_hi_r <= req_i.wdata;
        memmap_pkg::BANK_SELECTOR: bank_r <= req_i.wdata;
        memmap_pkg::PROGRAM_COUNTER_LATCH_HIGH: latch_hi_r <= req_i.wdata;
        memmap_pkg::IRQ_CONTROL: irqc_r <= req_i.wdata;
        memmap_pkg::CORE_FLAGS: flags_r <= req_i.wdata;
        // The counter low byte is owned by the sequencer, so it is dropped.
        default: begin
        end
      endcase
    end
  end

  // The accumulator also takes the low byte of a program read.
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      acc_r <= memmap_pkg::REG_RESET;
    end else if (stall_r && req_i.rd) begin
      acc_r <= prog_word_i[7:0];
    end else if (req_i.wr && !to_prog && is_core &&
                 dofs == memmap_pkg::ACCUMULATOR_ALIAS) begin
      acc_r <= req_i.wdata;
    end
  end

  // ****************************************
  // Response timing
  // ****************************************
  // A program read answers one cycle later than a data access, which is
  // the extra instruction cycle; the core must hold its request meanwhile.
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      stall_r <= 1'b0;
    end else begin
      stall_r <= !stall_r && access && to_prog;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
      extra_r <= 1'b0;
    end else if (stall_r) begin
      rdata_r <= req_i.rd ? prog_word_i[7:0] : 8'h00;
      rvalid_r <= 1'b1;
      extra_r <= 1'b1;
    end else if (access && !to_prog) begin
      rvalid_r <= 1'b1;
      extra_r <= 1'b0;
      if (!req_i.rd) begin
        rdata_r <= 8'h00;
      end else if (is_core) begin
        rdata_r <= core_rdata;
      end else if (is_gp || is_common) begin
        rdata_r <= gp_rdata;
      end else if (is_spec && spec_hit_i && int'(dbank) < SPEC_BANKS) begin
        rdata_r <= spec_rdata_i;
      end else begin
        rdata_r <= 8'h00;
      end
    end else begin
      rvalid_r <= 1'b0;
      extra_r <= 1'b0;
    end
  end

  assign rsp_o = '{valid: rvalid_r, extra_cycle: extra_r, rdata: rdata_r};

  // Program address is the pointer's low 15 bits masked to the program size; taking only those bits drops its steering bit.
  assign prog_addr_o = ptr_full[memmap_pkg::PC_W-1:0] &
                       memmap_pkg::PC_W'(PROG_WORDS - 1);
  assign prog_rd_o = access && to_prog && !stall_r;

  assign spec_rd_o = req_i.rd && !to_prog && is_spec;
  assign spec_wr_o = req_i.wr && !to_prog && is_spec;
  assign spec_addr_o = daddr;
  assign spec_wdata_o = req_i.wdata;
  assign bank_o = bank_r[memmap_pkg::BANK_W-1:0];
  assign accumulator_o = acc_r;

endmodule // core_memory_map_decode

/* shared/memmap_pkg.sv */
// Constants and carriers for the core memory map decode block.
package memmap_pkg;

  // ****************************************
  // Widths and sizes
  // ****************************************
  localparam int PC_W = 15;
  localparam int INSN_W = 14;
  localparam int DADDR_W = 12;
  localparam int BANK_W = 5;
  localparam int OFS_W = 7;
  localparam int PROG_WORDS_DEF = 4096;
  localparam int GP_BANKS_DEF = 3;
  localparam int GP_BYTES = 80;
  localparam int COMMON_BYTES = 16;

  // ****************************************
  // Vectors
  // ****************************************
  localparam logic [PC_W-1:0] RESET_VEC = 15'h0000;
  localparam logic [PC_W-1:0] IRQ_VEC = 15'h0004;

  // ****************************************
  // Bank layout offsets
  // ****************************************
  localparam logic [OFS_W-1:0] OFS_CORE_LAST = 7'h0b;
  localparam logic [OFS_W-1:0] OFS_SPEC_LAST = 7'h1f;
  localparam logic [OFS_W-1:0] OFS_GP_FIRST = 7'h20;
  localparam logic [OFS_W-1:0] OFS_GP_LAST = 7'h6f;
  localparam logic [OFS_W-1:0] OFS_COMMON_FIRST = 7'h70;

  // ****************************************
  // Core register offsets
  // ****************************************
  localparam logic [OFS_W-1:0] INDIRECT_DATA_0 = 7'h00;
  localparam logic [OFS_W-1:0] INDIRECT_DATA_1 = 7'h01;
  localparam logic [OFS_W-1:0] PROGRAM_COUNTER_LOW = 7'h02;
  localparam logic [OFS_W-1:0] CORE_FLAGS = 7'h03;
  localparam logic [OFS_W-1:0] POINTER0_LOW = 7'h04;
  localparam logic [OFS_W-1:0] POINTER0_HIGH = 7'h05;
  localparam logic [OFS_W-1:0] POINTER1_LOW = 7'h06;
  localparam logic [OFS_W-1:0] POINTER1_HIGH = 7'h07;
  localparam logic [OFS_W-1:0] BANK_SELECTOR = 7'h08;
  localparam logic [OFS_W-1:0] ACCUMULATOR_ALIAS = 7'h09;
  localparam logic [OFS_W-1:0] PROGRAM_COUNTER_LATCH_HIGH = 7'h0a;
  localparam logic [OFS_W-1:0] IRQ_CONTROL = 7'h0b;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int PTR_PROG_BIT = 7;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic rd;
    logic wr;
    logic indirect;
    logic ptr_sel;
    logic [OFS_W-1:0] offset;
    logic [7:0] wdata;
  } data_req_t;

  typedef struct packed {
    logic valid;
    logic extra_cycle;
    logic [7:0] rdata;
  } data_rsp_t;

endpackage

/* src/prog_addr_gen.sv */
// Program counter, vectors and program-space wrap.
`timescale 1ns/1ns
module prog_addr_gen #(
  parameter int PROG_WORDS = memmap_pkg::PROG_WORDS_DEF
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Sequencing controls from the execution core
  input wire logic advance_i,
  input wire logic irq_take_i,
  input wire logic jump_i,
  input wire logic [memmap_pkg::PC_W-1:0] jump_addr_i,
  // Program counter and fetch address
  output logic [memmap_pkg::PC_W-1:0] pc_o,
  output logic [memmap_pkg::PC_W-1:0] fetch_addr_o
);

  localparam logic [memmap_pkg::PC_W-1:0] TOP_MASK =
    memmap_pkg::PC_W'(PROG_WORDS - 1);

  logic [memmap_pkg::PC_W-1:0] pc_r;

  // The interrupt vector takes priority over a jump, which beats a step.
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pc_r <= memmap_pkg::RESET_VEC;
    end else if (irq_take_i) begin
      pc_r <= memmap_pkg::IRQ_VEC;
    end else if (jump_i) begin
      pc_r <= jump_addr_i;
    end else if (advance_i) begin
      pc_r <= pc_r + 15'h0001;
    end
  end

  assign pc_o = pc_r;
  // Sizes are powers of two, so masking gives the wrap-around.
  assign fetch_addr_o = pc_r & TOP_MASK;

endmodule // prog_addr_gen

/* src/gp_ram.sv */
// Byte-wide general purpose RAM held in flip-flops.
`timescale 1ns/1ns
module gp_ram #(
  parameter int DEPTH = memmap_pkg::GP_BYTES * memmap_pkg::GP_BANKS_DEF,
  parameter int AW = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Access port
  input wire logic we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);

  logic [7:0] mem_r [DEPTH];

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= memmap_pkg::REG_RESET;
      end
    end else if (we_i && (int'(addr_i) < DEPTH)) begin
      mem_r[addr_i] <= wdata_i;
    end
  end

  assign rdata_o = (int'(addr_i) < DEPTH) ? mem_r[addr_i] : 8'h00;

endmodule // gp_ram

/* sim/core_memory_map_decode_monitor.sv */
// Concurrent checks on the ports of the memory map decode block.
`timescale 1ns/1ns
module core_memory_map_decode_monitor #(
  parameter int PROG_WORDS = memmap_pkg::PROG_WORDS_DEF
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic advance_i,
  input wire logic irq_take_i,
  input wire logic jump_i,
  input wire logic [memmap_pkg::PC_W-1:0] jump_addr_i,
  input wire logic [memmap_pkg::PC_W-1:0] pc_o,
  input wire logic [memmap_pkg::PC_W-1:0] fetch_addr_o,
  input wire logic [memmap_pkg::PC_W-1:0] prog_addr_o,
  input wire logic prog_rd_o,
  input wire logic [memmap_pkg::INSN_W-1:0] prog_word_i,
  input wire memmap_pkg::data_req_t req_i,
  input wire memmap_pkg::data_rsp_t rsp_o,
  input wire logic spec_rd_o,
  input wire logic spec_wr_o,
  input wire logic [memmap_pkg::DADDR_W-1:0] spec_addr_o,
  input wire logic [memmap_pkg::BANK_W-1:0] bank_o
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_irq_vector: assert property (irq_take_i |=> pc_o == 15'h0004)
    else $error("pc did not load the interrupt vector");
  a_jump_load: assert property (!irq_take_i && jump_i |=>
    pc_o == $past(jump_addr_i)) else $error("pc missed a jump");
  a_pc_advance: assert property (!irq_take_i && !jump_i && advance_i |=>
    pc_o == $past(pc_o) + 15'h0001) else $error("pc missed a step");
  a_fetch_wrap: assert property (fetch_addr_o ==
    (pc_o & 15'(PROG_WORDS - 1))) else $error("fetch not wrapped");
  a_data_latency: assert property ((req_i.rd || req_i.wr) && !req_i.indirect
    |=> rsp_o.valid && !rsp_o.extra_cycle)
    else $error("direct answer late");
  a_prog_latency: assert property (prog_rd_o && req_i.rd |-> ##2 (
    rsp_o.valid && rsp_o.extra_cycle &&
    rsp_o.rdata == $past(prog_word_i[7:0])))
    else $error("program read answer wrong");
  a_prog_range: assert property (prog_rd_o |->
    prog_addr_o < 15'(PROG_WORDS)) else $error("program address");
  a_spec_addr: assert property ((spec_rd_o || spec_wr_o) &&
    !req_i.indirect |-> req_i.offset inside {[7'h0c:7'h1f]} &&
    spec_addr_o == {bank_o, req_i.offset})
    else $error("peripheral window address wrong");

  c_irq: cover property (irq_take_i);
  c_prog: cover property (prog_rd_o);
  c_spec: cover property (spec_rd_o);
endmodule // core_memory_map_decode_monitor

bind core_memory_map_decode core_memory_map_decode_monitor #(
  .PROG_WORDS(PROG_WORDS)
) u_mon (.clk_i(clk_i), .rstn_i(rstn_i), .advance_i(advance_i),
  .irq_take_i(irq_take_i), .jump_i(jump_i), .jump_addr_i(jump_addr_i),
  .pc_o(pc_o), .fetch_addr_o(fetch_addr_o), .prog_addr_o(prog_addr_o),
  .prog_rd_o(prog_rd_o), .prog_word_i(prog_word_i), .req_i(req_i),
  .rsp_o(rsp_o), .spec_rd_o(spec_rd_o), .spec_wr_o(spec_wr_o),
  .spec_addr_o(spec_addr_o), .bank_o(bank_o));

/* sim/prog_space_model.sv */
// Program memory and peripheral window seen by the decode block.
`timescale 1ns/1ns
module prog_space_model (
  input wire logic clk_i,
  input wire logic [14:0] prog_addr_i,
  input wire logic prog_rd_i,
  output logic [13:0] prog_word_o,
  input wire logic [11:0] spec_addr_i,
  input wire logic spec_wr_i,
  input wire logic [7:0] spec_wdata_i,
  output logic spec_hit_o,
  output logic [7:0] spec_rdata_o
);
  logic [7:0] junk_r = 8'h5a;
  logic [7:0] periph_r = 8'h5c;
  // The word is only valid the cycle after a read; otherwise it is inverted
  // so that a late sample by the block cannot pass by chance.
  always @(posedge clk_i) begin
    junk_r <= junk_r + 8'h3b;
    if (spec_wr_i && spec_hit_o) begin
      periph_r <= spec_wdata_i;
    end
    if (prog_rd_i) begin
      prog_word_o <= prog_addr_i[13:0] ^ 14'h1a5c;
    end else begin
      prog_word_o <= ~prog_word_o;
    end
  end
  assign spec_hit_o = (spec_addr_i == 12'h00c);
  assign spec_rdata_o = spec_hit_o ? periph_r : junk_r;
endmodule // prog_space_model

/* sim/core_memory_map_decode_tb_top.sv */
// Self-checking bench for the memory map decode block.
`timescale 1ns/1ns
module core_memory_map_decode_tb_top;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic advance_i = 1'b0;
  logic irq_take_i = 1'b0;
  logic jump_i = 1'b0;
  logic [14:0] jump_addr_i = 15'h0000;
  memmap_pkg::data_req_t req_i = '0;
  memmap_pkg::data_rsp_t rsp_o;
  logic [14:0] pc_o, fetch_addr_o, prog_addr_o;
  logic prog_rd_o, spec_hit_i, spec_wr_o;
  logic [13:0] prog_word_i;
  logic [11:0] spec_addr_o;
  logic [7:0] spec_rdata_i, spec_wdata_o, accumulator_o;
  logic [4:0] bank_o;
  int failures = 0;
  int checks = 0;
  int cyc = 0;

  core_memory_map_decode u_dut (.clk_i(clk_i), .rstn_i(rstn_i),
    .advance_i(advance_i), .irq_take_i(irq_take_i), .jump_i(jump_i),
    .jump_addr_i(jump_addr_i), .pc_o(pc_o), .fetch_addr_o(fetch_addr_o),
    .prog_addr_o(prog_addr_o), .prog_rd_o(prog_rd_o),
    .prog_word_i(prog_word_i), .req_i(req_i), .rsp_o(rsp_o),
    .spec_rd_o(), .spec_wr_o(spec_wr_o), .spec_addr_o(spec_addr_o),
    .spec_wdata_o(spec_wdata_o), .spec_hit_i(spec_hit_i),
    .spec_rdata_i(spec_rdata_i), .bank_o(bank_o),
    .accumulator_o(accumulator_o));
  prog_space_model u_far (.clk_i(clk_i), .prog_addr_i(prog_addr_o),
    .prog_rd_i(prog_rd_o), .prog_word_o(prog_word_i),
    .spec_addr_i(spec_addr_o), .spec_wr_i(spec_wr_o),
    .spec_wdata_i(spec_wdata_o), .spec_hit_o(spec_hit_i),
    .spec_rdata_o(spec_rdata_i));

  // ****************************************
  // Shared tasks
  // ****************************************
  always #10 clk_i = ~clk_i;

  task close_out;
    if (failures == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      close_out;
    end
  end

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One access; program-space requests are held for two edges.
  task automatic acc(input logic w, input logic ind, input logic ps,
    input logic [6:0] ofs, input logic [7:0] wd, input logic [7:0] exp,
    input logic prog);
    logic [7:0] got;
    logic xc;
    int lat;
    got = 8'hxx;
    xc = 1'bx;
    lat = 0;
    req_i = {~w, w, ind, ps, ofs, wd};
    for (int n = 1; n <= 4; n++) begin
      @(negedge clk_i);
      if (n == (prog ? 2 : 1)) req_i = '0;
      if (rsp_o.valid === 1'b1 && lat == 0) begin
        got = rsp_o.rdata;
        xc = rsp_o.extra_cycle;
        lat = n;
      end
    end
    chk(16'(lat), prog ? 16'h0002 : 16'h0001);
    chk({15'h0000, xc}, {15'h0000, prog});
    if (!w) chk({8'h00, got}, {8'h00, exp});
  endtask

  task wr(input logic [6:0] ofs, input logic [7:0] wd);
    acc(1'b1, 1'b0, 1'b0, ofs, wd, 8'h00, 1'b0);
  endtask

  task rd(input logic [6:0] ofs, input logic [7:0] exp);
    acc(1'b0, 1'b0, 1'b0, ofs, 8'h00, exp, 1'b0);
  endtask

  task step(input logic a, input logic i, input logic j,
    input logic [14:0] addr);
    advance_i = a;
    irq_take_i = i;
    jump_i = j;
    jump_addr_i = addr;
    @(negedge clk_i);
    {advance_i, irq_take_i, jump_i} = 3'h0;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task t_pc;
    chk(16'(pc_o), 16'h0000);
    repeat (3) step(1'b1, 1'b0, 1'b0, 15'h0000);
    chk(16'(pc_o), 16'h0003);
    step(1'b1, 1'b0, 1'b1, 15'h1ffe);
    chk(16'(fetch_addr_o), 16'h0ffe);
    repeat (2) step(1'b1, 1'b0, 1'b0, 15'h0000);
    chk(16'(pc_o), 16'h2000);
    chk(16'(fetch_addr_o), 16'h0000);
    step(1'b0, 1'b0, 1'b1, 15'h7fff);
    step(1'b1, 1'b0, 1'b0, 15'h0000);
    chk(16'(pc_o), 16'h0000);
    step(1'b1, 1'b1, 1'b1, 15'h0123);
    chk(16'(pc_o), 16'h0004);
  endtask

  task t_regs;
    // The counter low byte still shows the interrupt vector left by t_pc.
    for (int i = 0; i < 12; i++) rd(7'(i), (i == 2) ? 8'h04 : 8'h00);
    for (int i = 4; i < 12; i++) wr(7'(i), 8'(i));
    for (int i = 4; i < 12; i++) rd(7'(i), 8'(i));
    chk(16'(bank_o), 16'h0008);
  endtask

  task t_ram;
    wr(7'h08, 8'h01);
    wr(7'h20, 8'ha5);
    wr(7'h70, 8'h3c);
    wr(7'h08, 8'h00);
    rd(7'h20, 8'h00);
    rd(7'h70, 8'h3c);
    wr(7'h05, 8'h00);
    wr(7'h04, 8'ha0);
    acc(1'b0, 1'b1, 1'b0, 7'h00, 8'h00, 8'ha5, 1'b0);
    wr(7'h07, 8'h01);
    wr(7'h06, 8'h70);
    acc(1'b0, 1'b1, 1'b1, 7'h00, 8'h00, 8'h3c, 1'b0);
    wr(7'h08, 8'h03);
    rd(7'h20, 8'h00);
    rd(7'h08, 8'h03);
    wr(7'h08, 8'h02);
    wr(7'h6f, 8'h81);
    rd(7'h6f, 8'h81);
    wr(7'h08, 8'h00);
    rd(7'h0c, 8'h5c);
    wr(7'h0c, 8'h77);
    rd(7'h0c, 8'h77);
    rd(7'h0d, 8'h00);
  endtask

  task t_prog;
    logic [13:0] word;
    word = 14'h0234 ^ 14'h1a5c;
    wr(7'h07, 8'h92);
    wr(7'h06, 8'h34);
    acc(1'b0, 1'b1, 1'b1, 7'h00, 8'h00, word[7:0], 1'b1);
    chk({8'h00, accumulator_o}, {8'h00, word[7:0]});
    // Aim the pointer's data bits at a filled RAM byte (bank 1, 20h).
    wr(7'h07, 8'h80);
    wr(7'h06, 8'ha0);
    wr(7'h09, 8'h11);
    acc(1'b1, 1'b1, 1'b1, 7'h00, 8'hff, 8'h00, 1'b1);
    chk({8'h00, accumulator_o}, 16'h0011);
    acc(1'b0, 1'b1, 1'b0, 7'h00, 8'h00, 8'ha5, 1'b0);
    word = 14'h00a0 ^ 14'h1a5c;
    acc(1'b0, 1'b1, 1'b1, 7'h00, 8'h00, word[7:0], 1'b1);
  endtask

  initial begin
    repeat (2) @(negedge clk_i);
    rstn_i = 1'b1;
    t_pc;
    t_regs;
    t_ram;
    t_prog;
    close_out;
  end
endmodule // core_memory_map_decode_tb_top
